//--- inc/otc_pkg.sv
// otc_pkg: register map, field layout and shared types of the otp timing and copy block
`default_nettype none
package otc_pkg;
	localparam logic [31:0] OTC_TIM1_OFS = 32'h07f40010;
	localparam logic [31:0] OTC_TIM2_OFS = 32'h07f40014;
	localparam logic [31:0] OTC_DEST_OFS = 32'h07f40018;
	localparam logic [31:0] OTC_SRC_OFS = 32'h07f4001c;
	localparam logic [31:0] OTC_CNT_OFS = 32'h07f40020;
	localparam logic [31:0] OTC_STAT_OFS = 32'h07f40024;
	localparam logic [31:0] OTC_TIM1_RST = 32'h0999000f;
	localparam logic [31:0] OTC_TIM1_MASK = 32'h7fff737f;
	localparam logic [31:0] OTC_TIM2_RST = 32'ha4040409;
	localparam logic [31:0] OTC_TIM2_MASK = 32'hffff7fff;
	localparam logic [13:0] OTC_DEST_RST = 14'h0000;
	localparam logic [12:0] OTC_SRC_RST = 13'h0000;
	localparam logic [12:0] OTC_CNT_RST = 13'h0000;
	localparam int OTC_CPU_LSB = 0;
	localparam int OTC_CPU_W = 7;
	localparam int OTC_DEST_LSB = 2;
	localparam int OTC_DEST_W = 14;
	localparam int OTC_CELL_W = 13;
	localparam int OTC_STAT_WORDS_LSB = 16;
	localparam int OTC_FIFO_DEPTH = 4;
	localparam int OTC_DATA_W = 32;

	// second timing register, laid out bit for bit as software sees it
	typedef struct packed {
		logic extra_cycle_enable;
		logic [1:0] standby_exit_wait;
		logic [4:0] program_hold_wait;
		logic [2:0] supply_settle_wait;
		logic [4:0] program_setup_wait;
		logic reserved15;
		logic [6:0] program_recovery_wait;
		logic [2:0] pulse_gap_wait;
		logic [4:0] pulse_width;
	} otc_tim2_t;

	typedef enum logic [2:0] {
		OTC_IV_STANDBY_EXIT,
		OTC_IV_PROGRAM_HOLD,
		OTC_IV_SUPPLY_SETTLE,
		OTC_IV_PROGRAM_SETUP,
		OTC_IV_PROGRAM_RECOVERY,
		OTC_IV_PULSE_GAP,
		OTC_IV_PULSE_WIDTH
	} otc_interval_t;

	typedef struct packed {
		logic [OTC_DEST_W+1:0] addr;
		logic [OTC_DATA_W-1:0] data;
	} otc_bus_wr_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} otc_reg_req_t;
endpackage
`default_nettype wire

//--- src/otc_timing_copy.sv
// otc_timing_copy: otp interval timers, copy engine and its data fifo
//
// Summary of operation
// - tim2 bit 31 (reset 1) appends one clock cycle to every microsecond interval.
// - standby-exit wait, bits 30:29, microseconds minus one; at least 2 us.
// - program-hold wait after last pulse, bits 28:24; 5 to 20 us.
// - supply-settle wait before regulator enable, bits 23:21; at least 1 us.
// - program-setup wait before first pulse, bits 20:16; 5 to 20 us.
// - recovery after a programming sequence, bits 14:8; 5 to 100 us.
// - gap between successive pulses, bits 7:5; 1 to 5 us.
// - pulse width, bits 4:0 minus one, reset 9; 10 to 20 us.
// - bus write address takes bits 15:2 from destination register, bits 1:0 zero.
// - destination register changes only by software writes, never by the copy engine.
// - source cell register bits 12:0 give the first otp word for copy and mirror.
// - auto copy moves word count plus one words from otp to destination.
// - during mirroring the word count register shows the amount being copied.
// - one microsecond is cycles-per-microsecond field plus one clock periods, reset 0xf.
//
// Decided for this implementation: the strobed register port.
`default_nettype none

module otc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic push;
	logic pop;
	assign in_ready_o = (fill != (AW+1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module otc_timing_copy (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire otc_pkg::otc_reg_req_t reg_req_i,
	output logic [31:0] reg_rdata_o,
	input wire logic interval_start_i,
	input wire otc_pkg::otc_interval_t interval_sel_i,
	output logic interval_busy_o,
	output logic interval_done_o,
	input wire logic copy_start_i,
	input wire logic mirror_start_i,
	input wire logic [12:0] mirror_words_i,
	output logic copy_busy_o,
	output logic copy_done_o,
	output logic otp_rd_req_o,
	output logic [12:0] otp_rd_addr_o,
	input wire logic otp_rd_valid_i,
	input wire logic [31:0] otp_rd_data_i,
	output logic bus_wr_req_o,
	output otc_pkg::otc_bus_wr_t bus_wr_o,
	input wire logic bus_wr_ack_i
);
	import otc_pkg::*;
	typedef enum logic [1:0] {OTC_TM_IDLE, OTC_TM_COUNT, OTC_TM_EXTRA} otc_tm_state_t;
	typedef enum logic [0:0] {OTC_CP_IDLE, OTC_CP_RUN} otc_cp_state_t;
	logic [31:0] tim1;
	otc_tim2_t tim2;
	logic [OTC_DEST_W-1:0] dest_bus_addr;
	logic [OTC_CELL_W-1:0] source_word_addr;
	logic [OTC_CELL_W-1:0] word_count_minus_one;
	logic [OTC_CPU_W-1:0] cycles_per_microsecond;
	otc_tm_state_t tm_state;
	logic [6:0] cyc_cnt;
	logic [6:0] us_cnt;
	logic [6:0] us_target;
	otc_cp_state_t cp_state;
	logic [13:0] rd_issued;
	logic [13:0] wr_done;
	logic [13:0] total_words;
	logic [OTC_DEST_W-1:0] wr_word;
	logic rd_pending;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [31:0] fifo_out_data;
	logic next_issue;
	logic [31:0] next_rdata;
	// field of the selected interval, microseconds minus one
	function automatic logic [6:0] interval_field(input otc_interval_t sel, input otc_tim2_t t);
		case (sel)
			OTC_IV_STANDBY_EXIT: interval_field = 7'(t.standby_exit_wait);
			OTC_IV_PROGRAM_HOLD: interval_field = 7'(t.program_hold_wait);
			OTC_IV_SUPPLY_SETTLE: interval_field = 7'(t.supply_settle_wait);
			OTC_IV_PROGRAM_SETUP: interval_field = 7'(t.program_setup_wait);
			OTC_IV_PROGRAM_RECOVERY: interval_field = t.program_recovery_wait;
			OTC_IV_PULSE_GAP: interval_field = 7'(t.pulse_gap_wait);
			OTC_IV_PULSE_WIDTH: interval_field = 7'(t.pulse_width);
			default: interval_field = 7'h00;
		endcase
	endfunction
	function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
		hit = (a == ofs);
	endfunction
	assign cycles_per_microsecond = tim1[OTC_CPU_LSB +: OTC_CPU_W];
	// timing registers; range limits are left to software, values are taken as written less the bits cleared by the masks
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tim1 <= OTC_TIM1_RST;
			tim2 <= OTC_TIM2_RST;
		end else if (reg_req_i.wr) begin
			if (hit(reg_req_i.addr, OTC_TIM1_OFS)) begin
				tim1 <= reg_req_i.wdata & OTC_TIM1_MASK;
			end
			if (hit(reg_req_i.addr, OTC_TIM2_OFS)) begin
				tim2 <= reg_req_i.wdata & OTC_TIM2_MASK;
			end
		end
	end
	// only a software write reaches this register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			dest_bus_addr <= OTC_DEST_RST;
		end else if (reg_req_i.wr && hit(reg_req_i.addr, OTC_DEST_OFS)) begin
			dest_bus_addr <= reg_req_i.wdata[OTC_DEST_LSB +: OTC_DEST_W];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			source_word_addr <= OTC_SRC_RST;
		end else if (reg_req_i.wr && hit(reg_req_i.addr, OTC_SRC_OFS)) begin
			source_word_addr <= reg_req_i.wdata[OTC_CELL_W-1:0];
		end
	end
	// mirror start loads the amount it copies, winning over a software write
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			word_count_minus_one <= OTC_CNT_RST;
		end else if (mirror_start_i && cp_state == OTC_CP_IDLE) begin
			word_count_minus_one <= mirror_words_i;
		end else if (reg_req_i.wr && hit(reg_req_i.addr, OTC_CNT_OFS)) begin
			word_count_minus_one <= reg_req_i.wdata[OTC_CELL_W-1:0];
		end
	end
	always_comb begin
		next_rdata = 32'h00000000;
		if (hit(reg_req_i.addr, OTC_TIM1_OFS)) begin
			next_rdata = tim1;
		end else if (hit(reg_req_i.addr, OTC_TIM2_OFS)) begin
			next_rdata = tim2;
		end else if (hit(reg_req_i.addr, OTC_DEST_OFS)) begin
			next_rdata = 32'({dest_bus_addr, 2'b00});
		end else if (hit(reg_req_i.addr, OTC_SRC_OFS)) begin
			next_rdata = 32'(source_word_addr);
		end else if (hit(reg_req_i.addr, OTC_CNT_OFS)) begin
			next_rdata = 32'(word_count_minus_one);
		end else if (hit(reg_req_i.addr, OTC_STAT_OFS)) begin
			next_rdata = 32'({wr_done, 14'h0000, copy_busy_o, interval_busy_o});
		end
	end
	// read data stands only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= reg_req_i.rd ? next_rdata : 32'h00000000;
		end
	end
	// interval timer: microsecond ticks from the cycle prescaler, then optional extra cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tm_state <= OTC_TM_IDLE;
			cyc_cnt <= 7'h00;
			us_cnt <= 7'h00;
			us_target <= 7'h00;
			interval_done_o <= 1'b0;
			interval_busy_o <= 1'b0;
		end else begin
			interval_done_o <= 1'b0;
			case (tm_state)
				OTC_TM_IDLE: begin
					if (interval_start_i) begin
						us_target <= interval_field(interval_sel_i, tim2);
						cyc_cnt <= 7'h00;
						us_cnt <= 7'h00;
						interval_busy_o <= 1'b1;
						tm_state <= OTC_TM_COUNT;
					end
				end
				OTC_TM_COUNT: begin
					if (cyc_cnt == cycles_per_microsecond) begin
						cyc_cnt <= 7'h00;
						if (us_cnt == us_target) begin
							if (tim2.extra_cycle_enable) begin
								tm_state <= OTC_TM_EXTRA;
							end else begin
								tm_state <= OTC_TM_IDLE;
								interval_busy_o <= 1'b0;
								interval_done_o <= 1'b1;
							end
						end else begin
							us_cnt <= us_cnt + 7'h01;
						end
					end else begin
						cyc_cnt <= cyc_cnt + 7'h01;
					end
				end
				OTC_TM_EXTRA: begin
					tm_state <= OTC_TM_IDLE;
					interval_busy_o <= 1'b0;
					interval_done_o <= 1'b1;
				end
				default: begin
					tm_state <= OTC_TM_IDLE;
					interval_busy_o <= 1'b0;
				end
			endcase
		end
	end
	// one otp read outstanding at a time, and only with room in the fifo, so no word is dropped
	assign next_issue = (cp_state == OTC_CP_RUN) && !rd_pending && !otp_rd_req_o
		&& (rd_issued != total_words) && fifo_in_ready;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cp_state <= OTC_CP_IDLE;
			total_words <= 14'h0000;
			rd_issued <= 14'h0000;
			rd_pending <= 1'b0;
			otp_rd_req_o <= 1'b0;
			otp_rd_addr_o <= 13'h0000;
			copy_busy_o <= 1'b0;
		end else begin
			otp_rd_req_o <= next_issue;
			case (cp_state)
				OTC_CP_IDLE: begin
					if (copy_start_i || mirror_start_i) begin
						total_words <= mirror_start_i ? 14'(mirror_words_i) + 14'h0001
							: 14'(word_count_minus_one) + 14'h0001;
						rd_issued <= 14'h0000;
						rd_pending <= 1'b0;
						copy_busy_o <= 1'b1;
						cp_state <= OTC_CP_RUN;
					end
				end
				OTC_CP_RUN: begin
					if (next_issue) begin
						otp_rd_addr_o <= source_word_addr + rd_issued[12:0];
						rd_issued <= rd_issued + 14'h0001;
						rd_pending <= 1'b1;
					end else if (otp_rd_valid_i) begin
						rd_pending <= 1'b0;
					end
					if (copy_done_o) begin
						copy_busy_o <= 1'b0;
						cp_state <= OTC_CP_IDLE;
					end
				end
				default: begin
					cp_state <= OTC_CP_IDLE;
					copy_busy_o <= 1'b0;
				end
			endcase
		end
	end
	otc_fifo #(
		.WIDTH(OTC_DATA_W),
		.DEPTH(OTC_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(otp_rd_valid_i && rd_pending),
		.in_ready_o(fifo_in_ready),
		.in_data_i(otp_rd_data_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);
	// a stalled bus holds the output word, which backs the fifo up and stops otp reads
	assign fifo_out_ready = !bus_wr_req_o || bus_wr_ack_i;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			bus_wr_req_o <= 1'b0;
			bus_wr_o <= '0;
			wr_word <= '0;
		end else begin
			// a start while busy is ignored, so it must not rewind the write offset
			if (cp_state == OTC_CP_IDLE && (copy_start_i || mirror_start_i)) begin
				wr_word <= '0;
			end
			if (fifo_out_valid && fifo_out_ready) begin
				bus_wr_req_o <= 1'b1;
				bus_wr_o.addr <= {dest_bus_addr + wr_word, 2'b00};
				bus_wr_o.data <= fifo_out_data;
				wr_word <= wr_word + 14'h0001;
			end else if (bus_wr_ack_i) begin
				bus_wr_req_o <= 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_done <= 14'h0000;
			copy_done_o <= 1'b0;
		end else begin
			copy_done_o <= 1'b0;
			if (cp_state == OTC_CP_IDLE && (copy_start_i || mirror_start_i)) begin
				wr_done <= 14'h0000;
			end else if (bus_wr_req_o && bus_wr_ack_i) begin
				wr_done <= wr_done + 14'h0001;
				copy_done_o <= (wr_done + 14'h0001 == total_words);
			end
		end
	end
	// helper: cycles since a timer start, and the length that start should give
	logic [15:0] tm_elapsed;
	logic [15:0] tm_expect;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tm_elapsed <= 16'h0000;
			tm_expect <= 16'h0000;
		end else if (tm_state == OTC_TM_IDLE && interval_start_i) begin
			tm_elapsed <= 16'h0001;
			tm_expect <= 16'((interval_field(interval_sel_i, tim2) + 16'h0001) * (cycles_per_microsecond + 16'h0001)
				+ 16'(tim2.extra_cycle_enable) + 16'h0001);
		end else if (tm_state != OTC_TM_IDLE) begin
			tm_elapsed <= tm_elapsed + 16'h0001;
		end
	end
	AST_TIMER_LENGTH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		interval_done_o |-> tm_elapsed == tm_expect)
		else $error("interval length differs from field and prescaler");
	AST_EXTRA_CYCLE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(tm_state == OTC_TM_COUNT && cyc_cnt == cycles_per_microsecond && us_cnt == us_target
		&& tim2.extra_cycle_enable) |=> !interval_done_o ##1 interval_done_o)
		else $error("extra cycle not appended");
	AST_NO_EXTRA: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(tm_state == OTC_TM_COUNT && cyc_cnt == cycles_per_microsecond && us_cnt == us_target
		&& !tim2.extra_cycle_enable) |=> interval_done_o)
		else $error("interval ran past its end");
	AST_TICK_PERIOD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(tm_state == OTC_TM_COUNT && cyc_cnt == cycles_per_microsecond && us_cnt != us_target)
		|=> us_cnt == $past(us_cnt) + 7'h01 && cyc_cnt == 7'h00)
		else $error("microsecond tick not taken at prescaler end");
	AST_PULSE_FIELD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(tm_state == OTC_TM_IDLE && interval_start_i && interval_sel_i == OTC_IV_PULSE_WIDTH)
		|=> us_target == 7'($past(tim2.pulse_width)))
		else $error("pulse width field not loaded");
	AST_RECOVERY_FIELD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(tm_state == OTC_TM_IDLE && interval_start_i && interval_sel_i == OTC_IV_PROGRAM_RECOVERY)
		|=> us_target == $past(tim2.program_recovery_wait))
		else $error("recovery field not loaded");
	AST_WORD_ALIGN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		bus_wr_req_o |-> bus_wr_o.addr[1:0] == 2'b00)
		else $error("bus write address not word aligned");
	AST_DEST_STABLE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!$past(reg_req_i.wr) |-> $stable(dest_bus_addr))
		else $error("destination register changed without a write");
	AST_SRC_ADDR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		next_issue |=> otp_rd_req_o && otp_rd_addr_o == $past(source_word_addr) + $past(rd_issued[12:0]))
		else $error("otp read address not source plus offset");
	AST_WORD_TOTAL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		copy_done_o |-> wr_done == total_words && rd_issued == total_words)
		else $error("copy ended with wrong word total");
	AST_MIRROR_COUNT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(mirror_start_i && cp_state == OTC_CP_IDLE) |=> word_count_minus_one == $past(mirror_words_i)
		&& total_words == 14'($past(mirror_words_i)) + 14'h0001)
		else $error("mirror amount not shown in word count");
endmodule
`default_nettype wire

//--- tb/otc_otp_mem_model.sv
// otc_otp_mem_model: otp array and system memory seen from the copy engine
`default_nettype none
module otc_otp_mem_model (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic otp_rd_req_i,
	input wire logic [12:0] otp_rd_addr_i,
	output logic otp_rd_valid_o,
	output logic [31:0] otp_rd_data_o,
	input wire logic bus_wr_req_i,
	output logic bus_wr_ack_o,
	input wire logic [7:0] rd_lat_i,
	input wire logic [7:0] ack_lat_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rcnt;
	logic [7:0] wcnt;
	logic [12:0] raddr;
	// read word loaded only in the valid cycle; otherwise the previous value inverted, so stale data repeats the last word every other cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rcnt <= 8'h00;
			otp_rd_valid_o <= 1'b0;
			otp_rd_data_o <= 32'h00000000;
		end else if (otp_rd_req_i) begin
			rcnt <= rd_lat_i;
			raddr <= otp_rd_addr_i;
			otp_rd_valid_o <= 1'b0;
			otp_rd_data_o <= ~otp_rd_data_o;
		end else if (rcnt == 8'h01) begin
			rcnt <= 8'h00;
			otp_rd_valid_o <= 1'b1;
			otp_rd_data_o <= {19'h2b1c5, raddr};
		end else begin
			rcnt <= (rcnt == 8'h00) ? 8'h00 : rcnt - 8'h01;
			otp_rd_valid_o <= 1'b0;
			otp_rd_data_o <= ~otp_rd_data_o;
		end
	end
	// ack stalls for ack_lat_i cycles per word, a one-cycle pulse
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || bus_wr_ack_o) begin
			bus_wr_ack_o <= 1'b0;
			wcnt <= 8'h00;
		end else if (bus_wr_req_i) begin
			if (wcnt >= ack_lat_i) bus_wr_ack_o <= 1'b1;
			else wcnt <= wcnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// tb_top: self-checking bench for the otp timing and copy block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import otc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	otc_reg_req_t req = '0;
	logic [31:0] rdata;
	logic ist = 1'b0;
	otc_interval_t isel = OTC_IV_STANDBY_EXIT;
	logic ibusy, idone, cst = 1'b0, mst = 1'b0, cbusy, cdone;
	logic [12:0] mwords = 13'h0000;
	logic rreq, rvalid, wreq, wack;
	logic [12:0] raddr;
	logic [31:0] rdat;
	otc_bus_wr_t bwr;
	logic [7:0] rlat = 8'h01, alat = 8'h00;
	int num_errors = 0, cmp_count = 0, occ = 0, occ_max = 0;
	logic [15:0] wa_q[$];
	logic [31:0] wd_q[$];
	logic [12:0] ra_q[$];

	always #12.5 ref_clk_i = ~ref_clk_i;

	otc_timing_copy dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.interval_start_i(ist), .interval_sel_i(isel), .interval_busy_o(ibusy), .interval_done_o(idone),
		.copy_start_i(cst), .mirror_start_i(mst), .mirror_words_i(mwords), .copy_busy_o(cbusy),
		.copy_done_o(cdone), .otp_rd_req_o(rreq), .otp_rd_addr_o(raddr), .otp_rd_valid_i(rvalid),
		.otp_rd_data_i(rdat), .bus_wr_req_o(wreq), .bus_wr_o(bwr), .bus_wr_ack_i(wack));
	otc_otp_mem_model partner (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .otp_rd_req_i(rreq),
		.otp_rd_addr_i(raddr), .otp_rd_valid_o(rvalid), .otp_rd_data_o(rdat), .bus_wr_req_i(wreq),
		.bus_wr_ack_o(wack), .rd_lat_i(rlat), .ack_lat_i(alat));

	// traffic monitor; occ tracks words fetched but not yet accepted
	always @(posedge ref_clk_i) begin
		if (rreq === 1'b1) begin
			ra_q.push_back(raddr);
			occ++;
		end
		if (wreq === 1'b1 && wack === 1'b1) begin
			wa_q.push_back(bwr.addr);
			wd_q.push_back(bwr.data);
			occ--;
		end
		if (occ > occ_max) occ_max = occ;
	end

	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus access; read data taken in the single cycle it stands
	task automatic reg_acc(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk_i);
		req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge ref_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
		#1 q = rdata;
	endtask

	task automatic reg_table();
		logic [31:0] q;
		logic [31:0] ad[6] = '{OTC_TIM1_OFS, OTC_TIM2_OFS, OTC_DEST_OFS, OTC_SRC_OFS, OTC_CNT_OFS, 32'h07f40028};
		logic [31:0] rv[6] = '{OTC_TIM1_RST, OTC_TIM2_RST, 32'h0, 32'h0, 32'h0, 32'h0};
		logic [31:0] ov[6] = '{OTC_TIM1_MASK, OTC_TIM2_MASK, 32'h0000fffc, 32'h00001fff, 32'h00001fff, 32'h0};
		for (int i = 0; i < 6; i++) begin
			reg_acc(1'b0, ad[i], 32'h0, q);
			chk(q, rv[i]);
		end
		for (int i = 0; i < 6; i++) begin
			reg_acc(1'b1, ad[i], 32'hffffffff, q);
			reg_acc(1'b0, ad[i], 32'h0, q);
			chk(q, ov[i]);
			// back to reset values so the timer scenarios start from them
			reg_acc(1'b1, ad[i], rv[i], q);
		end
	endtask

	// start one interval and count edges until done
	task automatic time_one(input otc_interval_t s, input int f, input int c, input int e);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		ist <= 1'b1;
		isel <= s;
		@(posedge ref_clk_i);
		ist <= 1'b0;
		do begin
			@(posedge ref_clk_i);
			#1 n++;
			if (n < (f + 1) * (c + 1) + e) chk({31'h0, ibusy}, 32'h1);
		end while (idone !== 1'b1 && n < 400);
		chk(32'(n), 32'((f + 1) * (c + 1) + e));
	endtask

	task automatic timers();
		logic [31:0] q;
		otc_tim2_t t;
		int f;
		time_one(OTC_IV_PULSE_WIDTH, 9, 15, 1);
		reg_acc(1'b1, OTC_TIM1_OFS, 32'h00000002, q);
		for (int e = 1; e >= 0; e--) begin
			t = '{extra_cycle_enable: e[0], standby_exit_wait: 2'h1, program_hold_wait: 5'h02,
				supply_settle_wait: 3'h3, program_setup_wait: 5'h04, reserved15: 1'b0,
				program_recovery_wait: 7'h05, pulse_gap_wait: 3'h6, pulse_width: 5'h07};
			reg_acc(1'b1, OTC_TIM2_OFS, t, q);
			for (int s = 0; s < 7; s++) begin
				f = s + 1;
				time_one(otc_interval_t'(s), f, 2, e);
			end
		end
	endtask

	// copy or mirror run, with a second start mid-run that must be ignored
	task automatic copy_run(input logic mir, input logic [12:0] src, input logic [13:0] dw, input logic [12:0] nw);
		logic [31:0] q;
		int k;
		wa_q.delete();
		wd_q.delete();
		ra_q.delete();
		occ_max = 0;
		reg_acc(1'b1, OTC_DEST_OFS, {16'h0, dw, 2'b00}, q);
		reg_acc(1'b1, OTC_SRC_OFS, {19'h0, src}, q);
		reg_acc(1'b1, OTC_CNT_OFS, {19'h0, mir ? 13'h0abc : nw}, q);
		@(posedge ref_clk_i);
		cst <= !mir;
		mst <= mir;
		mwords <= nw;
		@(posedge ref_clk_i);
		cst <= 1'b0;
		mst <= 1'b0;
		reg_acc(1'b0, OTC_CNT_OFS, 32'h0, q);
		chk(q, {19'h0, nw});
		// second start only after a word has landed, so a rewound offset would show
		k = 0;
		do begin
			@(posedge ref_clk_i);
			#1 k++;
		end while (wa_q.size() == 0 && k < 200);
		@(posedge ref_clk_i);
		cst <= !mir;
		mst <= mir;
		mwords <= 13'h0111;
		@(posedge ref_clk_i);
		cst <= 1'b0;
		mst <= 1'b0;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			#1 k++;
		end while (cdone !== 1'b1 && k < 3000);
		chk({31'h0, cdone}, 32'h1);
		@(posedge ref_clk_i);
		#1 chk({31'h0, cbusy}, 32'h0);
		chk(32'(wa_q.size()), 32'(nw) + 32'h1);
		for (k = 0; k <= nw && k < wa_q.size(); k++) begin
			chk({16'h0, wa_q[k]}, {16'h0, dw + 14'(k), 2'b00});
			chk(wd_q[k], {19'h2b1c5, src + 13'(k)});
			chk({19'h0, ra_q[k]}, {19'h0, src + 13'(k)});
		end
		reg_acc(1'b0, OTC_DEST_OFS, 32'h0, q);
		chk(q, {16'h0, dw, 2'b00});
		reg_acc(1'b0, OTC_CNT_OFS, 32'h0, q);
		chk(q, {19'h0, nw});
		reg_acc(1'b0, OTC_STAT_OFS, 32'h0, q);
		chk(q, (32'(nw) + 32'h1) << OTC_STAT_WORDS_LSB);
		if (occ_max > OTC_FIFO_DEPTH + 2) chk(32'(occ_max), 32'(OTC_FIFO_DEPTH + 2));
	endtask

	initial begin
		repeat (5) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		reg_table();
		timers();
		rlat <= 8'h03;
		copy_run(1'b0, 13'h0100, 14'h0010, 13'h0002);
		alat <= 8'h14;
		rlat <= 8'h01;
		copy_run(1'b1, 13'h1ffd, 14'h3ffe, 13'h0005);
		stop_test();
	end

	// watchdog: the whole run needs well under 20,000 cycles
	initial begin
		#500us;
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
